// [shared/plb_pkg.sv]
`default_nettype none
package plb_pkg;
	// register addresses on the internal management port
	localparam logic [4:0] ADDR_BMC = 5'h00;
	localparam logic [4:0] ADDR_CTL1 = 5'h09;
	localparam logic [4:0] ADDR_RES0 = 5'h10;
	localparam logic [4:0] ADDR_RSTAT = 5'h15;
	localparam logic [4:0] ADDR_STC = 5'h16;
	localparam logic [4:0] ADDR_ERR = 5'h1B;
	localparam logic [4:0] ADDR_LEN = 5'h1C;
	localparam logic [4:0] ADDR_XLOC = 5'h1E;
	// field positions
	localparam int BMC_MAC_LOOP = 14;
	localparam int CTL1_AUTO_REFL = 8;
	localparam int STC_PCS_IN = 0;
	localparam int STC_PCS_OUT = 1;
	localparam int STC_DIGITAL = 2;
	localparam int STC_ANALOG = 3;
	localparam int STC_REVERSE = 4;
	localparam int STC_RUN = 5;
	localparam int STC_TXLOOP = 6;
	localparam int STC_BUSY = 9;
	localparam int STC_LOCK = 10;
	localparam int STC_LOST = 11;
	localparam int STC_LONG = 12;
	localparam int STC_SINGLE = 13;
	localparam int STC_CONT = 14;
	localparam int RSTAT_START = 0;
	// writable bits and reset values
	localparam logic [15:0] STC_WMASK = 16'h707F;
	localparam logic [15:0] BMC_RST = 16'h0000;
	localparam logic [15:0] CTL1_RST = 16'h0000;
	localparam logic [15:0] STC_RST = 16'h0000;
	localparam logic [15:0] LEN_RST = 16'h0040;
	// self-test constants
	localparam logic [14:0] PRBS_SEED = 15'h7FFF;
	localparam logic [11:0] SHORT_BYTES = 12'h040;
	localparam logic [11:0] LONG_BYTES = 12'h5EE;
	localparam logic [3:0] CONST_NIB = 4'h5;
	localparam logic [3:0] LOCK_LAST = 4'h7;
	localparam logic [3:0] LOSS_LAST = 4'h3;
	localparam logic [12:0] GAP_MIN = 13'h0008;
	// reflectometry limits
	localparam logic [2:0] MAX_REFL = 3'h5;
	localparam logic [2:0] MAX_REFL_X = 3'h4;
	localparam int REFL_N = 5;
	// transmit buffer word: {tx_en, nibble}
	localparam int BUF_W = 5;
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_PKT = 2'b01,
		G_GAP = 2'b11,
		G_DONE = 2'b10
	} plb_gen_t;
endpackage
`default_nettype wire

// [verilog/plb_diag.sv]
// Contract
// - MAC loopback when basic control bit 14.
// - self-test control bits 0-3 pick loop point.
// - each loop only in its supported settings.
// - MAC loopback reports no link, returns packets.
// - bit 6 also sends MAC loop at 100.
// - loop bits clear means normal paths.
// - bit 4 loops line data back out.
// - reverse loop feeds MAC, ignores MAC inputs.
// - reverse loop on reduced interface only 10.
// - independent paths, 15-bit pseudo-random generator.
// - checker compares, counts errored bytes.
// - status shows lock, sync loss, busy.
// - bit 14 picks wrap or saturate counting.
// - packet length follows length register.
// - bit 13 single 64/1518 constant packet.
// - packets separated by controllable gaps.
// - keep first five reflections only.
// - cross fault keeps location plus four.
// - link failure may auto-launch reflectometry.
`default_nettype none
module plb_diag
	import plb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic speed_100,
	input wire logic auto_negotiated,
	input wire logic rmii_mode,
	input wire logic link_ok_in,
	output logic link_up,
	input wire logic mac_tx_en,
	input wire logic [3:0] mac_txd,
	output logic tx_ready,
	output logic mac_rx_dv,
	output logic [3:0] mac_rxd,
	output logic line_tx_valid,
	output logic line_tx_en,
	output logic [3:0] line_txd,
	input wire logic line_tx_ready,
	input wire logic line_rx_dv,
	input wire logic [3:0] line_rxd,
	output logic loop_pcs_in,
	output logic loop_pcs_out,
	output logic loop_digital,
	output logic loop_analog,
	output logic refl_test_run,
	input wire logic refl_valid,
	input wire logic refl_cross,
	input wire logic [11:0] refl_time,
	input wire logic refl_done
);

	// four steps of x^15+x^14+1; returns {next state, nibble msb first}
	function automatic logic [18:0] prbs_step4(input logic [14:0] s);
		logic [14:0] st;
		logic [3:0] nib;
		st = s;
		nib = 4'h0;
		for (int i = 0; i < 4; i++) begin
			nib = {nib[2:0], st[14] ^ st[13]};
			st = {st[13:0], st[14] ^ st[13]};
		end
		return {st, nib};
	endfunction

	logic [15:0] bmc_q, ctl1_q, stc_q, len_q, err_q;
	logic run_d1_q, start_p, wr_stc;
	logic mac_loop, rev_loop, bist_run;
	plb_gen_t gen_q;
	logic [12:0] gen_cnt_q, pkt_nibs, gap_nibs;
	logic [14:0] prbs_q, chk_q;
	logic [18:0] gen_nx, chk_nx;
	logic gen_busy;
	logic [BUF_W-1:0] src_d, out_d_q, skid_d_q;
	logic out_v_q, skid_free_q;
	logic nib_ok, lock_q, lost_q, phase_q, byte_bad_q, err_inc;
	logic [3:0] good_q, bad_q;
	logic link_d_q, refl_start, refl_x_q;
	logic [2:0] refl_cnt_q;
	logic [11:0] xloc_q;
	logic [11:0] refl_mem_q [REFL_N];
	logic [2:0] res_idx;
	logic [15:0] rd_d, stc_view;

	assign wr_stc = reg_wr && reg_addr == ADDR_STC;
	assign bist_run = stc_q[STC_RUN];
	assign start_p = bist_run && !run_d1_q;
	// reverse loop not allowed at 100 on the reduced interface
	assign rev_loop = stc_q[STC_REVERSE] && !(rmii_mode && speed_100);
	// reverse loop takes precedence; MAC loop needs the full interface
	assign mac_loop = bmc_q[BMC_MAC_LOOP] && !rmii_mode && !rev_loop;

	// software-writable configuration
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bmc_q <= BMC_RST;
			ctl1_q <= CTL1_RST;
			stc_q <= STC_RST;
			len_q <= LEN_RST;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_BMC)
				bmc_q <= reg_wdata;
			if (reg_addr == ADDR_CTL1)
				ctl1_q <= reg_wdata;
			if (wr_stc)
				stc_q <= reg_wdata & STC_WMASK;
			if (reg_addr == ADDR_LEN)
				len_q <= reg_wdata;
		end
	end

	// run edge detect and link history
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_d1_q <= 1'b0;
			link_d_q <= 1'b0;
		end else begin
			run_d1_q <= bist_run;
			link_d_q <= link_ok_in;
		end
	end

	// loop point selects, gated to the settings each supports;
	// pcs and digital loops need a forced speed (no negotiation); analog also runs negotiated at 10
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_pcs_in <= 1'b0;
			loop_pcs_out <= 1'b0;
			loop_digital <= 1'b0;
			loop_analog <= 1'b0;
		end else begin
			loop_pcs_in <= stc_q[STC_PCS_IN] && !auto_negotiated;
			loop_pcs_out <= stc_q[STC_PCS_OUT] && !auto_negotiated && speed_100;
			loop_digital <= stc_q[STC_DIGITAL] && !auto_negotiated && speed_100;
			loop_analog <= stc_q[STC_ANALOG] && (!auto_negotiated || !speed_100);
		end
	end

	// MAC receive side and reported link
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mac_rx_dv <= 1'b0;
			mac_rxd <= 4'h0;
			link_up <= 1'b0;
		end else begin
			link_up <= link_ok_in && !mac_loop;
			if (mac_loop) begin
				mac_rx_dv <= mac_tx_en;
				mac_rxd <= mac_txd;
			end else begin
				mac_rx_dv <= line_rx_dv;
				mac_rxd <= line_rxd;
			end
		end
	end

	// generator packet and gap sizes in nibbles
	always_comb begin
		if (stc_q[STC_SINGLE])
			pkt_nibs = {stc_q[STC_LONG] ? LONG_BYTES : SHORT_BYTES, 1'b0};
		else
			pkt_nibs = {len_q[11:0], 1'b0};
		gap_nibs = {6'h00, len_q[15:12], 3'h0} + GAP_MIN;
	end

	assign gen_nx = prbs_step4(prbs_q);
	assign gen_busy = gen_q == G_PKT || gen_q == G_GAP;

	// transmit source: generator, reverse loop, MAC, or idle;
	// MAC inputs are dropped whenever reverse loop owns the line
	always_comb begin
		if (bist_run)
			src_d = {gen_q == G_PKT,
				stc_q[STC_SINGLE] ? CONST_NIB : gen_nx[3:0]};
		else if (rev_loop)
			src_d = {line_rx_dv, line_rxd};
		else if (mac_loop && !(stc_q[STC_TXLOOP] && speed_100))
			src_d = {1'b0, 4'h0};
		else
			src_d = {mac_tx_en, mac_txd};
	end

	// packet generator; advances only when the buffer takes a word
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			gen_q <= G_IDLE;
			gen_cnt_q <= 13'h0000;
			prbs_q <= PRBS_SEED;
		end else if (!bist_run) begin
			gen_q <= G_IDLE;
			gen_cnt_q <= 13'h0000;
		end else if (skid_free_q) begin
			case (gen_q)
				G_IDLE: begin
					gen_q <= G_PKT;
					gen_cnt_q <= 13'h0000;
				end
				G_PKT: begin
					prbs_q <= gen_nx[18:4];
					gen_cnt_q <= gen_cnt_q + 13'h0001;
					if (gen_cnt_q == pkt_nibs - 13'h0001) begin
						gen_q <= G_GAP;
						gen_cnt_q <= 13'h0000;
					end
				end
				G_GAP: begin
					gen_cnt_q <= gen_cnt_q + 13'h0001;
					if (gen_cnt_q == gap_nibs - 13'h0001) begin
						gen_q <= stc_q[STC_SINGLE] ? G_DONE : G_PKT;
						gen_cnt_q <= 13'h0000;
					end
				end
				G_DONE: gen_q <= G_DONE;
				default: gen_q <= G_IDLE;
			endcase
		end
	end

	// two-entry skid buffer toward the line; output slot plus spare,
	// so a stall by the line never drops the word in flight
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_v_q <= 1'b0;
			out_d_q <= '0;
			skid_d_q <= '0;
			skid_free_q <= 1'b1;
		end else if (!out_v_q || line_tx_ready) begin
			out_v_q <= 1'b1;
			if (!skid_free_q) begin
				out_d_q <= skid_d_q;
				skid_free_q <= 1'b1;
			end else
				out_d_q <= src_d;
		end else if (skid_free_q) begin
			skid_d_q <= src_d;
			skid_free_q <= 1'b0;
		end
	end

	assign line_tx_valid = out_v_q;
	assign line_tx_en = out_d_q[4];
	assign line_txd = out_d_q[3:0];
	assign tx_ready = skid_free_q;

	// checker predicts from the last 15 received bits (self-synchronising)
	assign chk_nx = prbs_step4(chk_q);
	assign nib_ok = line_rxd == chk_nx[3:0];

	// checker lock, sync loss and byte phase
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chk_q <= PRBS_SEED;
			lock_q <= 1'b0;
			lost_q <= 1'b0;
			good_q <= 4'h0;
			bad_q <= 4'h0;
			phase_q <= 1'b0;
			byte_bad_q <= 1'b0;
		end else if (start_p) begin
			lock_q <= 1'b0;
			lost_q <= 1'b0;
			good_q <= 4'h0;
			bad_q <= 4'h0;
			phase_q <= 1'b0;
			byte_bad_q <= 1'b0;
		end else if (bist_run && line_rx_dv) begin
			chk_q <= {chk_q[10:0], line_rxd};
			phase_q <= !phase_q;
			byte_bad_q <= !phase_q && !nib_ok;
			if (!lock_q) begin
				good_q <= nib_ok ? good_q + 4'h1 : 4'h0;
				if (nib_ok && good_q == LOCK_LAST)
					lock_q <= 1'b1;
			end else if (!nib_ok) begin
				bad_q <= bad_q + 4'h1;
				if (bad_q == LOSS_LAST) begin
					lock_q <= 1'b0;
					lost_q <= 1'b1;
					good_q <= 4'h0;
					bad_q <= 4'h0;
				end
			end else
				bad_q <= 4'h0;
		end
	end

	// a byte counts once if either of its nibbles missed
	assign err_inc = bist_run && line_rx_dv && lock_q && phase_q
		&& (byte_bad_q || !nib_ok);

	// errored byte counter; single mode stops at full scale
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			err_q <= 16'h0000;
		else if (start_p)
			err_q <= 16'h0000;
		else if (err_inc) begin
			if (err_q != 16'hFFFF)
				err_q <= err_q + 16'h0001;
			else if (stc_q[STC_CONT])
				err_q <= 16'h0000;
		end
	end

	// reflectometry launch by software or by a link drop
	assign refl_start = (reg_wr && reg_addr == ADDR_RSTAT && reg_wdata[RSTAT_START])
		|| (ctl1_q[CTL1_AUTO_REFL] && link_d_q && !link_ok_in);

	// reflection capture; results stay until the next launch
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			refl_test_run <= 1'b0;
			refl_cnt_q <= 3'h0;
			refl_x_q <= 1'b0;
			xloc_q <= 12'h000;
		end else if (refl_start) begin
			refl_test_run <= 1'b1;
			refl_cnt_q <= 3'h0;
			refl_x_q <= 1'b0;
		end else if (refl_test_run) begin
			if (refl_done)
				refl_test_run <= 1'b0;
			else if (refl_valid && refl_cross && !refl_x_q) begin
				refl_x_q <= 1'b1;
				xloc_q <= refl_time;
				if (refl_cnt_q == MAX_REFL)
					refl_cnt_q <= MAX_REFL_X;
			end else if (refl_valid && !refl_cross
				&& refl_cnt_q < (refl_x_q ? MAX_REFL_X : MAX_REFL))
				refl_cnt_q <= refl_cnt_q + 3'h1;
		end
	end

	// reflection time slots, one per stored reflection
	for (genvar i = 0; i < REFL_N; i++) begin : g_refl
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n)
				refl_mem_q[i] <= 12'h000;
			else if (refl_test_run && !refl_done && refl_valid && !refl_cross
				&& refl_cnt_q == 3'(i) && refl_cnt_q < (refl_x_q ? MAX_REFL_X : MAX_REFL))
				refl_mem_q[i] <= refl_time;
		end
	end

	// read view of control register with live status
	always_comb begin
		stc_view = stc_q;
		stc_view[STC_BUSY] = gen_busy;
		stc_view[STC_LOCK] = lock_q;
		stc_view[STC_LOST] = lost_q;
		res_idx = 3'(reg_addr - ADDR_RES0);
		case (reg_addr)
			ADDR_BMC: rd_d = bmc_q;
			ADDR_CTL1: rd_d = ctl1_q;
			ADDR_STC: rd_d = stc_view;
			ADDR_ERR: rd_d = err_q;
			ADDR_LEN: rd_d = len_q;
			ADDR_RSTAT: rd_d = {11'h000, refl_test_run, refl_x_q, refl_cnt_q};
			ADDR_XLOC: rd_d = {4'h0, xloc_q};
			default: begin
				if (reg_addr >= ADDR_RES0 && reg_addr < ADDR_RSTAT)
					rd_d = {4'h0, refl_mem_q[res_idx]};
				else
					rd_d = 16'h0000;
			end
		endcase
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_d;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_good8;
		(bist_run && line_rx_dv && nib_ok && !start_p)[*8];
	endsequence
	sequence s_link_drop;
		ctl1_q[CTL1_AUTO_REFL] && link_d_q && !link_ok_in;
	endsequence

	property p_mac_loop;
		mac_loop |=> mac_rx_dv == $past(mac_tx_en) && mac_rxd == $past(mac_txd);
	endproperty
	a_mac_loop: assert property (p_mac_loop) else $error("mac loop data lost");
	property p_no_link;
		mac_loop |=> !link_up;
	endproperty
	a_no_link: assert property (p_no_link) else $error("link shown in mac loop");
	property p_dig_loop;
		stc_q[STC_DIGITAL] && !auto_negotiated && speed_100 |=> loop_digital;
	endproperty
	a_dig_loop: assert property (p_dig_loop) else $error("digital loop not set");
	property p_analog_gate;
		auto_negotiated && speed_100 |=> !loop_analog;
	endproperty
	a_analog_gate: assert property (p_analog_gate) else $error("analog loop at auto_negotiated 100");
	property p_mac_tx_off;
		mac_loop && !bist_run && !(stc_q[STC_TXLOOP] && speed_100) |-> !src_d[4];
	endproperty
	a_mac_tx_off: assert property (p_mac_tx_off) else $error("loop data sent to line");
	property p_rev_mac;
		rev_loop && line_rx_dv |=> mac_rx_dv && mac_rxd == $past(line_rxd);
	endproperty
	a_rev_mac: assert property (p_rev_mac) else $error("reverse data not at mac");
	property p_rev_rmii;
		rmii_mode && speed_100 |-> !rev_loop;
	endproperty
	a_rev_rmii: assert property (p_rev_rmii) else $error("reverse loop rmii 100");
	property p_lock;
		s_good8 |=> lock_q;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock after 8 good nibbles");
	property p_sat;
		!stc_q[STC_CONT] && err_q == 16'hFFFF && !start_p |=> err_q == 16'hFFFF;
	endproperty
	a_sat: assert property (p_sat) else $error("single mode counter moved");
	property p_wrap;
		stc_q[STC_CONT] && err_q == 16'hFFFF && err_inc |=> err_q == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("continuous counter no wrap");
	property p_const;
		bist_run && stc_q[STC_SINGLE] && gen_q == G_PKT |-> src_d[3:0] == CONST_NIB;
	endproperty
	a_const: assert property (p_const) else $error("single packet not constant");
	property p_refl_cap;
		refl_cnt_q <= (refl_x_q ? MAX_REFL_X : MAX_REFL);
	endproperty
	a_refl_cap: assert property (p_refl_cap) else $error("too many reflections");
	property p_auto;
		s_link_drop |=> refl_test_run && refl_cnt_q == 3'h0;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto reflectometry");
	property p_start;
		start_p |=> err_q == 16'h0000 && !lock_q && !lost_q;
	endproperty
	a_start: assert property (p_start) else $error("run start did not clear");

endmodule
`default_nettype wire

// [sim/plb_line_model.sv]
`default_nettype none
// cable-side stand-in: loops accepted line words back to the receiver
module plb_line_model
	import plb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic stall,
	input wire logic inject,
	input wire logic rx_force,
	input wire logic [3:0] rx_val,
	input wire logic line_tx_valid,
	input wire logic line_tx_en,
	input wire logic [3:0] line_txd,
	output logic line_tx_ready,
	output logic line_rx_dv,
	output logic [3:0] line_rxd,
	output logic [11:0] burst_len,
	output logic [11:0] gap_len,
	output logic const_ok
);
	logic [1:0] cyc_q;
	logic [11:0] run_q;
	logic [11:0] gap_q;
	logic ok_q;
	logic take;
	// one refusal in four while stalling, so the skid buffer must hold
	assign line_tx_ready = !(stall && cyc_q == 2'h3);
	assign take = line_tx_valid && line_tx_ready;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) cyc_q <= 2'h0;
		else cyc_q <= cyc_q + 2'h1;
	end
	// echo words; idle cycles flip data so nothing stale can match
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_rx_dv <= 1'b0;
			line_rxd <= 4'h0;
		end else if (rx_force) begin
			line_rx_dv <= 1'b1;
			line_rxd <= rx_val;
		end else begin
			line_rx_dv <= take && line_tx_en;
			line_rxd <= take ? (line_txd ^ {4{inject}}) : ~line_rxd;
		end
	end
	// packet and gap lengths counted in accepted words
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= 12'h000;
			gap_q <= 12'h000;
			ok_q <= 1'b1;
			burst_len <= 12'h000;
			gap_len <= 12'h000;
			const_ok <= 1'b0;
		end else if (take && line_tx_en) begin
			run_q <= run_q + 12'h001;
			ok_q <= ok_q && line_txd == CONST_NIB;
			if (gap_q != 12'h000) gap_len <= gap_q;
			gap_q <= 12'h000;
		end else if (take) begin
			gap_q <= gap_q + 12'h001;
			if (run_q != 12'h000) begin
				burst_len <= run_q;
				const_ok <= ok_q;
			end
			run_q <= 12'h000;
			ok_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [sim/test_phy_loopback_bist_diag.sv]
`default_nettype none
module test_phy_loopback_bist_diag import plb_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic arst_n, reg_wr, reg_rd, reg_rvalid, speed_100, auto_negotiated, rmii_mode;
	logic link_ok_in, link_up, mac_tx_en, tx_ready, mac_rx_dv, line_tx_valid, line_tx_en;
	logic line_tx_ready, line_rx_dv, loop_pcs_in, loop_pcs_out, loop_digital, loop_analog;
	logic refl_test_run, refl_valid, refl_cross, refl_done, stall, inject, rx_force, const_ok;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [3:0] mac_txd, mac_rxd, line_txd, line_rxd, rx_val;
	logic [11:0] refl_time, burst_len, gap_len;
	logic [15:0] exp_loop [4] = '{16'h9, 16'hF, 16'h1, 16'h0};
	int err_count = 0;
	int n_tests = 0;
	int i;
	always #2.5 ref_clk = ~ref_clk;
	plb_diag u_plb_diag(.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reg_rvalid, .speed_100, .auto_negotiated, .rmii_mode, .link_ok_in,
		.link_up, .mac_tx_en, .mac_txd, .tx_ready, .mac_rx_dv, .mac_rxd, .line_tx_valid,
		.line_tx_en, .line_txd, .line_tx_ready, .line_rx_dv, .line_rxd, .loop_pcs_in,
		.loop_pcs_out, .loop_digital, .loop_analog, .refl_test_run, .refl_valid,
		.refl_cross, .refl_time, .refl_done);
	plb_line_model u_plb_line_model(.ref_clk, .arst_n, .stall, .inject, .rx_force, .rx_val,
		.line_tx_valid, .line_tx_en, .line_txd, .line_tx_ready, .line_rx_dv, .line_rxd,
		.burst_len, .gap_len, .const_ok);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timeout();
		err_count++;
		$display("mismatch at %0t: wait ran out", $time);
		complete_run();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// register port: strobe for one cycle, read data follows rvalid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
		// let an edge pass so a following write sees a clean strobe
		cyc(1);
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		int k;
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) cyc(1);
		if (reg_rvalid !== 1'b1) timeout();
		d = reg_rdata;
		cyc(1);
	endtask
	task automatic chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		rd(a, v);
		check(v & m, e);
	endtask
	task automatic wait_reg(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e,
		input int n);
		int k;
		for (k = 0; k < n; k++) begin
			rd(a, v);
			if ((v & m) === e) return;
		end
		timeout();
	endtask
	task automatic pulse(input logic c, input logic [11:0] t, input logic d);
		refl_valid = !d;
		refl_cross = c;
		refl_time = t;
		refl_done = d;
		cyc(1);
		refl_valid = 1'b0;
		refl_done = 1'b0;
		cyc(1);
	endtask
	initial begin
		{arst_n, reg_wr, reg_rd, rmii_mode, mac_tx_en, refl_valid, refl_cross} = '0;
		{refl_done, stall, inject, auto_negotiated} = '0;
		{speed_100, link_ok_in, rx_force} = 3'h7;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		mac_txd = 4'hA;
		rx_val = 4'h3;
		refl_time = 12'h000;
		cyc(16);
		arst_n = 1'b1;
		cyc(2);
		// reset values, unmapped and read-only places
		chk(ADDR_BMC, 16'hFFFF, BMC_RST);
		chk(ADDR_CTL1, 16'hFFFF, CTL1_RST);
		chk(ADDR_STC, 16'hFFFF, STC_RST);
		chk(ADDR_LEN, 16'hFFFF, LEN_RST);
		wr(5'h05, 16'hFFFF);
		chk(5'h05, 16'hFFFF, 16'h0000);
		wr(ADDR_ERR, 16'h1234);
		chk(ADDR_ERR, 16'hFFFF, 16'h0000);
		wr(ADDR_STC, 16'hFFDF);
		chk(ADDR_STC, STC_WMASK, 16'h705F);
		// loop point per bit, then per operating setting
		for (i = 0; i < 4; i++) begin
			wr(ADDR_STC, 16'(1 << i));
			cyc(2);
			check(16'({loop_pcs_in, loop_pcs_out, loop_digital, loop_analog}), 16'(8 >> i));
		end
		wr(ADDR_STC, 16'h000F);
		for (i = 0; i < 4; i++) begin
			{auto_negotiated, speed_100} = 2'(i);
			cyc(2);
			check(16'({loop_pcs_in, loop_pcs_out, loop_digital, loop_analog}), exp_loop[i]);
		end
		{auto_negotiated, speed_100, mac_tx_en} = 3'h3;
		wr(ADDR_STC, 16'h0000);
		cyc(4);
		check(16'({line_tx_valid, line_tx_en, line_txd, mac_rxd, link_up}), 16'h747);
		// MAC loop: one cycle back to the MAC, link hidden
		wr(ADDR_BMC, 16'h4000);
		for (i = 0; i < 8; i++) begin
			mac_txd = 4'(i);
			cyc(1);
			check(16'({mac_rx_dv, mac_rxd}), 16'(16 + i));
		end
		check(16'(link_up), 16'h0);
		check(16'(line_tx_en), 16'h0);
		wr(ADDR_STC, 16'h0040);
		cyc(4);
		check(16'({line_tx_en, line_txd}), 16'h17);
		rmii_mode = 1'b1;
		cyc(3);
		check(16'(mac_rxd), 16'h3);
		rmii_mode = 1'b0;
		wr(ADDR_BMC, 16'h0000);
		// reverse loop ignores the MAC side
		wr(ADDR_STC, 16'h0010);
		mac_txd = 4'hA;
		cyc(4);
		check(16'({line_txd, mac_rxd}), 16'h33);
		rmii_mode = 1'b1;
		cyc(4);
		check(16'(line_txd), 16'hA);
		speed_100 = 1'b0;
		cyc(4);
		check(16'(line_txd), 16'h3);
		{rmii_mode, speed_100} = 2'b01;
		wr(ADDR_STC, 16'h0000);
		// line stalls: the skid buffer must refuse
		stall = 1'b1;
		for (i = 0; i < 20 && tx_ready !== 1'b0; i++) cyc(1);
		if (tx_ready !== 1'b0) timeout();
		// self test through the external loop, line still stalling
		rx_force = 1'b0;
		wr(ADDR_LEN, 16'h1010);
		chk(ADDR_LEN, 16'hFFFF, 16'h1010);
		wr(ADDR_STC, 16'h4020);
		wait_reg(ADDR_STC, 16'h0400, 16'h0400, 100);
		cyc(300);
		check(16'(burst_len), 16'd32);
		check(16'(gap_len), 16'd16);
		chk(ADDR_STC, 16'h0E00, 16'h0600);
		chk(ADDR_ERR, 16'hFFFF, 16'h0000);
		inject = 1'b1;
		// long enough to span a whole gap and reach packet data
		cyc(60);
		inject = 1'b0;
		chk(ADDR_STC, 16'h0800, 16'h0800);
		rd(ADDR_ERR, v);
		check(16'(v != 16'h0000), 16'h1);
		// no stalls from here, so the checker sees unbroken nibble runs
		stall = 1'b0;
		wr(ADDR_STC, 16'h4000);
		wr(ADDR_STC, 16'h4020);
		chk(ADDR_ERR, 16'hFFFF, 16'h0000);
		chk(ADDR_STC, 16'h0800, 16'h0000);
		wait_reg(ADDR_STC, 16'h0400, 16'h0400, 50);
		wr(ADDR_STC, 16'h0000);
		// single constant packets, short then long
		for (i = 0; i < 2; i++) begin
			cyc(200);
			wr(ADDR_STC, i ? 16'h3020 : 16'h2020);
			// busy must rise first, or an idle generator reads as finished
			wait_reg(ADDR_STC, 16'h0200, 16'h0200, 20);
			wait_reg(ADDR_STC, 16'h0200, 16'h0000, 3000);
			check(16'(burst_len), i ? 16'd3036 : 16'd128);
			check(16'(const_ok), 16'h1);
			wr(ADDR_STC, 16'h0000);
		end
		// reflectometry: first five kept, then cross fault
		wr(ADDR_RSTAT, 16'h0001);
		check(16'(refl_test_run), 16'h1);
		for (i = 1; i < 7; i++) pulse(1'b0, 12'(i), 1'b0);
		pulse(1'b0, 12'h000, 1'b1);
		chk(ADDR_RSTAT, 16'h001F, 16'h0005);
		for (i = 0; i < 5; i++) chk(ADDR_RES0 + 5'(i), 16'h0FFF, 16'(i + 1));
		wr(ADDR_RSTAT, 16'h0001);
		pulse(1'b0, 12'h001, 1'b0);
		pulse(1'b0, 12'h002, 1'b0);
		pulse(1'b1, 12'h077, 1'b0);
		for (i = 3; i < 6; i++) pulse(1'b0, 12'(i), 1'b0);
		pulse(1'b0, 12'h000, 1'b1);
		chk(ADDR_RSTAT, 16'h001F, 16'h000C);
		chk(ADDR_XLOC, 16'h0FFF, 16'h0077);
		chk(ADDR_RES0 + 5'h3, 16'h0FFF, 16'h0004);
		// link drop launches the test only when enabled
		link_ok_in = 1'b0;
		cyc(10);
		check(16'(refl_test_run), 16'h0);
		link_ok_in = 1'b1;
		wr(ADDR_CTL1, 16'h0100);
		chk(ADDR_CTL1, 16'hFFFF, 16'h0100);
		link_ok_in = 1'b0;
		for (i = 0; i < 10 && refl_test_run !== 1'b1; i++) cyc(1);
		if (refl_test_run !== 1'b1) timeout();
		pulse(1'b0, 12'h000, 1'b1);
		check(16'(refl_test_run), 16'h0);
		complete_run();
	end
endmodule
`default_nettype wire
